// >>> rtl/power_good_fault_reset_ctrl.sv
// Power-good generation, fault latches, soft reset and fall event flag.
// Assumes a byte register port driven by the serial interface logic on
// ref_clk, and analog status levels that arrive asynchronously.
`default_nettype none
`include "pwr_good_params.svh"

module power_good_fault_reset_ctrl
  import pwr_good_pkg::*;
#(
  parameter int N = `PG_NUM_OUTPUTS
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  input  wire logic [N-1:0] output_valid,
  input  wire logic [N-1:0] output_enabled,
  input  wire logic [N-1:0] startup_done,
  input  wire logic         thermal_warn,
  output logic              power_good_out,
  output logic              soft_reset_cmd
);
  logic [N-1:0] valid_m, valid_s, en_m, en_s, up_m, up_s;
  logic         twarn_m, twarn_s;
  logic [7:0]   ctrl1_q, ctrl1_d;
  logic [2:0]   ctrl2_q, ctrl2_d;
  logic         rst_cmd_q, rst_cmd_d;
  logic         evt_q, evt_d;
  logic         pg_active_q, pg_active_d;
  logic         pin_q, pin_d;
  logic [7:0]   rdata_q, rdata_d;
  logic [N-1:0] contrib, fail_now, fault_clr, fault_q;
  logic         fall, wr_evt, bad;
  power_good_op_mode_t mode;

  // True when the address equals the given register address, whether or not a write is strobed.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = (a == t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for analog status levels.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      valid_m <= '0;
      valid_s <= '0;
      en_m    <= '0;
      en_s    <= '0;
      up_m    <= '0;
      up_s    <= '0;
      twarn_m <= 1'b0;
      twarn_s <= 1'b0;
    end else begin
      valid_m <= output_valid;
      valid_s <= valid_m;
      en_m    <= output_enabled;
      en_s    <= en_m;
      up_m    <= startup_done;
      up_s    <= up_m;
      twarn_m <= thermal_warn;
      twarn_s <= twarn_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring selection and failure detection.
  assign mode = power_good_op_mode_t'(ctrl2_q[`PG_CTRL2_MODE_BIT]);
  assign contrib = ctrl1_q[N-1:0] &
                   ((mode == MODE_CONTINUOUS) ? {N{1'b1}} : (en_s & up_s));
  assign fail_now = contrib & ~valid_s;
  assign wr_evt   = reg_wr && hit(reg_addr, `PG_ADDR_EVENTS);
  assign fault_clr = (reg_wr && hit(reg_addr, `PG_ADDR_FAULT)) ?
                     (reg_wdata[N-1:0] & valid_s) : '0;

  fault_latch_bank #(
    .N (N)
  ) u_faults (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clr_all (rst_cmd_q),
    .set_req (fail_now),
    .clr_req (fault_clr),
    .flags_q (fault_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power-good level, pin polarity and fall detection.
  always_comb begin
    if (ctrl2_q[`PG_CTRL2_SRC_BIT]) begin
      bad = |fault_q | |fail_now; // A fresh fault counts before it latches.
    end else begin
      bad = |fail_now;
    end
    if (ctrl2_q[`PG_CTRL2_TWARN_BIT] && twarn_s) begin
      bad = 1'b1;
    end
    pg_active_d = !bad;
    pin_d = pg_active_d ^ ctrl1_q[`PG_CTRL1_POL_BIT];
    fall  = pg_active_q && !pg_active_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, soft reset and event flag next values.
  always_comb begin
    ctrl1_d   = ctrl1_q;
    ctrl2_d   = ctrl2_q;
    rst_cmd_d = 1'b0;
    evt_d     = evt_q;
    if (rst_cmd_q) begin
      ctrl1_d = `PG_CTRL1_RESET;
      ctrl2_d = 3'(`PG_CTRL2_RESET);
      evt_d   = 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, `PG_ADDR_CTRL1)) begin
        ctrl1_d = reg_wdata;
      end
      if (reg_wr && hit(reg_addr, `PG_ADDR_CTRL2)) begin
        ctrl2_d = reg_wdata[2:0];
      end
      if (reg_wr && hit(reg_addr, `PG_ADDR_RESET)) begin
        rst_cmd_d = reg_wdata[`PG_RESET_CMD_BIT];
      end
      if (wr_evt && reg_wdata[`PG_EVENT_FALL_BIT]) begin
        evt_d = 1'b0;
      end
    end
    if (fall) begin
      evt_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, registered one cycle after the read strobe.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `PG_ADDR_CTRL1:  rdata_d = ctrl1_q;
        `PG_ADDR_CTRL2:  rdata_d = {5'h00, ctrl2_q};
        `PG_ADDR_FAULT:  rdata_d = {{(8-N){1'b0}}, fault_q};
        `PG_ADDR_RESET:  rdata_d = 8'h00;
        `PG_ADDR_EVENTS: rdata_d = {evt_q, 7'h00};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl1_q     <= `PG_CTRL1_RESET;
      ctrl2_q     <= 3'(`PG_CTRL2_RESET);
      rst_cmd_q   <= 1'b0;
      evt_q       <= 1'b0;
      pg_active_q <= 1'b0;
      pin_q       <= 1'b1;
      rdata_q     <= 8'h00;
    end else begin
      ctrl1_q     <= ctrl1_d;
      ctrl2_q     <= ctrl2_d;
      rst_cmd_q   <= rst_cmd_d;
      evt_q       <= evt_d;
      pg_active_q <= pg_active_d;
      pin_q       <= pin_d;
      rdata_q     <= rdata_d;
    end
  end

  assign power_good_out = pin_q;
  assign soft_reset_cmd = rst_cmd_q; // One-cycle pulse to reload and serial.
  assign reg_rdata      = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence soft_written_s;
    reg_wr && hit(reg_addr, `PG_ADDR_RESET) && reg_wdata[0];
  endsequence

  twarn_gate_a: assert property (
    (ctrl2_q[2] && twarn_s) |=> !pg_active_q)
    else $error("thermal warning did not force power-good inactive");
  live_source_a: assert property (
    (!ctrl2_q[1] && !(ctrl2_q[2] && twarn_s) && fail_now == '0)
      |=> pg_active_q)
    else $error("live source not followed");
  latched_source_a: assert property (
    (ctrl2_q[1] && fault_q != '0) |=> !pg_active_q)
    else $error("latched fault did not hold power-good off");
  gated_mode_a: assert property (
    (!ctrl2_q[0] && ctrl1_q[2] && !en_s[2]) |-> !contrib[2])
    else $error("gated mode counted a disabled output");
  soft_reset_seq_a: assert property (
    (soft_written_s and !rst_cmd_q) |=> rst_cmd_q ##1 (!rst_cmd_q &&
      ctrl1_q == 8'h00 && ctrl2_q == 3'h0 && fault_q == '0))
    else $error("soft reset did not restore defaults");
  soft_self_clear_a: assert property (
    rst_cmd_q |=> !rst_cmd_q)
    else $error("soft reset bit did not self clear");
  fall_event_a: assert property (
    fall |=> evt_q)
    else $error("fall event not captured");
  evt_clear_a: assert property (
    (wr_evt && reg_wdata[7] && !fall && !rst_cmd_q) |=> !evt_q)
    else $error("event flag not cleared by write of one");
  evt_zero_write_a: assert property (
    (evt_q && wr_evt && !reg_wdata[7] && !rst_cmd_q) |=> evt_q)
    else $error("write of zero cleared the event flag");
  pin_polarity_a: assert property (
    1'b1 |=> power_good_out == (pg_active_q ^ $past(ctrl1_q[7])))
    else $error("pin level does not match polarity");
  monitor_off_a: assert property (
    !ctrl1_q[1] |-> !fail_now[1])
    else $error("unmonitored output caused a failure");
endmodule
`default_nettype wire

// >>> shared/pwr_good_params.svh
// Register offsets, field positions and reset values of the power-good block.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef PWR_GOOD_PARAMS_SVH
`define PWR_GOOD_PARAMS_SVH

`define PG_ADDR_CTRL1     8'h15
`define PG_ADDR_CTRL2     8'h16
`define PG_ADDR_FAULT     8'h17
`define PG_ADDR_RESET     8'h18
`define PG_ADDR_EVENTS    8'h19

`define PG_CTRL1_POL_BIT  7
`define PG_CTRL2_TWARN_BIT 2
`define PG_CTRL2_SRC_BIT  1
`define PG_CTRL2_MODE_BIT 0
`define PG_RESET_CMD_BIT  0
`define PG_EVENT_FALL_BIT 7

`define PG_CTRL1_RESET    8'h00
`define PG_CTRL2_RESET    8'h00
`define OUTPUT_FAULT_LATCH_RESET    4'h0
`define PG_NUM_OUTPUTS    4

`endif

// >>> shared/pwr_good_pkg.sv
// Types shared by the power-good control logic.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pwr_good_pkg;
  // Operating mode of the power-good output.
  typedef enum logic [0:0] {
    MODE_GATED      = 1'b0,
    MODE_CONTINUOUS = 1'b1
  } power_good_op_mode_t;
endpackage
`default_nettype wire

// >>> rtl/fault_latch_bank.sv
// Bank of sticky per-output fault flags for the power-good logic.
// Assumes set and clear requests come from logic on the same clock.
`default_nettype none
`include "pwr_good_params.svh"

module fault_latch_bank #(
  parameter int N = `PG_NUM_OUTPUTS
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clr_all,
  input  wire logic [N-1:0] set_req,
  input  wire logic [N-1:0] clr_req,
  output logic      [N-1:0] flags_q
);
  logic [N-1:0] flags_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next flag values; a new fault beats a per-output clear in the same cycle, but clr_all beats both.
  always_comb begin
    flags_d = flags_q;
    if (clr_all) begin
      flags_d = `OUTPUT_FAULT_LATCH_RESET;
    end else begin
      flags_d = (flags_q & ~clr_req) | set_req;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_q <= `OUTPUT_FAULT_LATCH_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on flag behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  fault_flag_set_a: assert property (
    (!clr_all && set_req[0]) |=> flags_q[0])
    else $error("fault flag did not set");
  fault_flag_hold_a: assert property (
    (!clr_all && flags_q[1] && !clr_req[1]) |=> flags_q[1])
    else $error("fault flag dropped without clear");
  fault_flag_clear_a: assert property (
    (clr_req[2] && !set_req[2]) |=> !flags_q[2])
    else $error("fault flag did not clear");
endmodule
`default_nettype wire

// >>> sim/rail_status_model.sv
// Model of the regulated outputs and thermal sensor seen by power-good.
// Assumes the bench steers faults, enables and start-up at its falling edge.
`default_nettype none
module rail_status_model (
  input  wire logic [3:0] fail,
  input  wire logic [3:0] not_started,
  input  wire logic [3:0] off,
  input  wire logic       hot,
  output logic      [3:0] output_valid,
  output logic      [3:0] output_enabled,
  output logic      [3:0] startup_done,
  output logic            thermal_warn
);
  timeunit 1ns;
  timeprecision 1ns;
  // A rail that has not started is never valid, which is the hazard
  // that gated mode exists to hide.
  // A rail switched off is neither enabled nor valid.
  assign output_enabled = ~off;
  assign startup_done   = ~not_started;
  assign output_valid   = ~fail & ~not_started & ~off;
  assign thermal_warn   = hot;
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench of the power-good, fault latch and soft reset logic.
// Assumes the byte register port and the rail model as the far side.
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] fail = 4'h0, not_started = 4'h0, off = 4'h0, output_valid;
  logic [3:0] output_enabled, startup_done;
  logic       hot = 1'b0, thermal_warn, power_good_out, soft_reset_cmd;
  int         error_cnt = 0, tests_run = 0, cyc = 0, pulse_cnt = 0;
  always #50 ref_clk = ~ref_clk;
  power_good_fault_reset_ctrl i_power_good_fault_reset_ctrl (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .output_valid(output_valid), .output_enabled(output_enabled),
    .startup_done(startup_done), .thermal_warn(thermal_warn),
    .power_good_out(power_good_out), .soft_reset_cmd(soft_reset_cmd));
  rail_status_model i_rail_status_model (
    .fail(fail), .not_started(not_started), .hot(hot), .off(off),
    .output_valid(output_valid), .output_enabled(output_enabled),
    .startup_done(startup_done), .thermal_warn(thermal_warn));
  ////////////////////////////////////////////////////////////////////////
  // Cycle ceiling and soft reset pulse counter.
  always @(posedge ref_clk) begin
    cyc++;
    if (soft_reset_cmd === 1'b1) pulse_cnt++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Register port write, one strobe cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // Register read compared with an expected byte.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a; reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
  endtask
  // Pin check after the synchroniser latency has run out.
  task automatic pg(input logic e);
    repeat (6) @(negedge ref_clk);
    `CHK(power_good_out, e)
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Defaults after reset, including an unmapped address.
  task automatic t_defaults();
    rc(8'h16, 8'h00);
    rc(8'h17, 8'h00);
    rc(8'h18, 8'h00);
    rc(8'h19, 8'h00);
    rc(8'h20, 8'h00);
  endtask
  // Polarity, thermal gate and reserved bits of the second control byte.
  task automatic t_pol_thermal();
    wr(8'h15, 8'h0f);
    pg(1'b1);
    wr(8'h15, 8'h8f);
    pg(1'b0);
    wr(8'h15, 8'h0f);
    wr(8'h16, 8'hf8);
    rc(8'h16, 8'h00);
    hot = 1'b1;
    pg(1'b1);
    wr(8'h16, 8'h04);
    pg(1'b0);
    hot = 1'b0;
    pg(1'b1);
    rc(8'h19, 8'h80);
    wr(8'h19, 8'h80);
    wr(8'h16, 8'h00);
  endtask
  // Fault latch, event flag clearing and the latched source select.
  task automatic t_fault();
    fail = 4'h4;
    pg(1'b0);
    rc(8'h17, 8'h04);
    wr(8'h19, 8'h00);
    rc(8'h19, 8'h80);
    wr(8'h19, 8'h80);
    rc(8'h19, 8'h00);
    wr(8'h17, 8'h0f);
    rc(8'h17, 8'h04);
    fail = 4'h0;
    pg(1'b1);
    wr(8'h16, 8'h02);
    pg(1'b0);
    wr(8'h17, 8'h04);
    rc(8'h17, 8'h00);
    pg(1'b1);
    wr(8'h19, 8'h80);
  endtask
  // Monitor enables, then gated against continuous mode.
  task automatic t_modes();
    wr(8'h16, 8'h00);
    wr(8'h15, 8'h0e);
    fail = 4'h1;
    pg(1'b1);
    rc(8'h17, 8'h00);
    fail = 4'h0;
    off = 4'h4;
    pg(1'b1);
    rc(8'h17, 8'h00);
    off = 4'h0;
    not_started = 4'h2;
    pg(1'b1);
    wr(8'h16, 8'h01);
    pg(1'b0);
    rc(8'h17, 8'h02);
  endtask
  // Soft reset pulses once and restores the defaults read back from 0x16 to 0x19.
  task automatic t_soft_reset();
    pulse_cnt = 0;
    wr(8'h18, 8'h01);
    repeat (3) @(negedge ref_clk);
    `CHK(pulse_cnt, 1)
    rc(8'h18, 8'h00);
    rc(8'h16, 8'h00);
    rc(8'h17, 8'h00);
    rc(8'h19, 8'h00);
    pg(1'b1);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    t_defaults();
    t_pol_thermal();
    t_fault();
    t_modes();
    t_soft_reset();
    results();
  end
endmodule
`default_nettype wire
